// ### rtl/standby_wake_defines.vh
`ifndef STANDBY_WAKE_DEFINES_VH
`define STANDBY_WAKE_DEFINES_VH

// clock and time base
`define CLK_FREQ_HZ 100000000
`define US_PER_S 1000000

// operating modes
`define MODE_ACTIVE 2'h0
`define MODE_LP_STANDBY 2'h1
`define MODE_BAT_STANDBY 2'h2

// register offsets
`define OFF_MODE_CTRL 8'h00
`define OFF_WAKE_CFG 8'h04
`define OFF_TIMER_CFG 8'h08
`define OFF_HS_CFG 8'h0C
`define OFF_STATUS 8'h10

// mode control fields
`define MC_MODE_LSB 0
`define MC_CAN_TRANSCEIVER_ACTIVATE 2

// wake configuration fields
`define WC_EN_LSB 0
`define WC_PULLUP_LSB 3
`define WC_CYCLIC 6
`define WC_CYC_TSEL 7
`define WC_FILT_SEL 8
`define WC_LIN_EN 9
`define WC_CAN_EN 10
`define WAKE_CFG_RESET 11'h607

// timer configuration fields
`define TC_T1_PER_LSB 0
`define TC_T1_ON 2
`define TC_T2_PER_LSB 3
`define TC_T2_ON 5
`define TC_TWAKE_EN 6
`define TC_TWAKE_SEL 7
`define TIMER_CFG_RESET 8'h00

// status fields
`define ST_LEVEL_LSB 0
`define ST_MODE_LSB 3
`define ST_SRC_LSB 5
`define ST_FAILSAFE 9

// hs output assignment codes
`define HS_OFF 2'h0
`define HS_ON 2'h1
`define HS_T1 2'h2
`define HS_T2 2'h3

// times in microseconds
`define STATIC_FILT_US 10'h040
`define CYC_FILT_US 10'h010
`define CYC_DELAY_SHORT_US 10'h050
`define CYC_DELAY_LONG_US 10'h320
`define INT_PULSE_US 10'h038
`define RST_PULSE_US 10'h064
`define BUS_FILT_US 10'h01E

// timer 1: periods 1..4 s, on 10/20 ms
`define T1_PER_1S 22'h0F4240
`define T1_PER_2S 22'h1E8480
`define T1_PER_3S 22'h2DC6C0
`define T1_PER_4S 22'h3D0900
`define T1_ON_10MS 22'h002710
`define T1_ON_20MS 22'h004E20
// timer 2: periods 10/20/50/200 ms, on 100 us / 1 ms
`define T2_PER_10MS 22'h002710
`define T2_PER_20MS 22'h004E20
`define T2_PER_50MS 22'h00C350
`define T2_PER_200MS 22'h030D40
`define T2_ON_100US 22'h000064
`define T2_ON_1MS 22'h0003E8

`endif

// ### rtl/cyclic_timer.v
`timescale 1ns/10ps
module cyclic_timer (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // control
  input wire tick,
  input wire restart,
  input wire [21:0] period_us,
  input wire [21:0] on_us,
  // phase and events
  output reg on_phase,
  output reg on_start,
  output reg expired
);
  reg [21:0] cnt_reg;
  wire [21:0] cnt_inc = cnt_reg + 22'h000001;
  wire [21:0] off_len = period_us - on_us;

  // each period is the off phase followed by the on phase
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 22'h000000;
      on_phase <= 1'b0;
      on_start <= 1'b0;
      expired <= 1'b0;
    end else if (restart) begin
      cnt_reg <= 22'h000000;
      on_phase <= 1'b0;
      on_start <= 1'b0;
      expired <= 1'b0;
    end else begin
      on_start <= 1'b0;
      expired <= 1'b0;
      if (tick) begin
        if (cnt_inc >= period_us) begin
          cnt_reg <= 22'h000000;
          on_phase <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_reg <= cnt_inc;
          if (cnt_inc == off_len) begin
            on_phase <= 1'b1;
            on_start <= 1'b1;
          end
        end
      end
    end
  end
endmodule // cyclic_timer

// ### rtl/standby_wake_and_cyclic_sense.v
`timescale 1ns/10ps
`include "standby_wake_defines.vh"
module standby_wake_and_cyclic_sense #(
  parameter US_CYCLES = `CLK_FREQ_HZ / `US_PER_S
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  // pins from outside
  input wire [2:0] contact_wake_inputs,
  input wire lin_bus_rx,
  input wire can_bus_rx,
  input wire fail_safe_condition,
  // pins and controls to outside
  output reg [4:0] high_side_outputs,
  output reg [2:0] wake_pull_up_en,
  output reg lin_receive_interrupt_pin_n,
  output reg micro_reset_out_n,
  output reg main_regulator_en,
  output reg watchdog_long_window,
  output reg can_trx_standby,
  output reg fail_safe_output,
  output reg oscillator_run
);
  localparam CS_IDLE = 2'h0;
  localparam CS_DELAY = 2'h1;
  localparam CS_FILT = 2'h2;

  function [21:0] t1_period;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: t1_period = `T1_PER_1S;
        2'h1: t1_period = `T1_PER_2S;
        2'h2: t1_period = `T1_PER_3S;
        default: t1_period = `T1_PER_4S;
      endcase
    end
  endfunction

  function [21:0] t2_period;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: t2_period = `T2_PER_10MS;
        2'h1: t2_period = `T2_PER_20MS;
        2'h2: t2_period = `T2_PER_50MS;
        default: t2_period = `T2_PER_200MS;
      endcase
    end
  endfunction

  // reset release and input synchronisers
  reg [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  reg [5:0] pin_s1_reg;
  reg [5:0] pin_s2_reg;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
    end else begin
      pin_s1_reg <= {fail_safe_condition, can_bus_rx, lin_bus_rx, contact_wake_inputs};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  wire [2:0] wu_lvl = pin_s2_reg[2:0];
  wire [1:0] bus_lvl = pin_s2_reg[4:3];
  wire fs_lvl = pin_s2_reg[5];

  // microsecond tick; the whole time base scales with US_CYCLES
  reg [15:0] pre_reg;
  reg tick_reg;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (pre_reg == US_CYCLES[15:0] - 16'h0001) begin
      pre_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      pre_reg <= pre_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // configuration registers
  reg [1:0] mode_reg;
  reg can_transceiver_activate_reg;
  reg [10:0] wake_cfg_reg;
  reg [7:0] timer_cfg_reg;
  reg [9:0] hs_cfg_reg;
  reg [3:0] src_reg;
  reg timer_restart_reg;

  wire standby = (mode_reg != `MODE_ACTIVE);
  wire [2:0] wu_en = wake_cfg_reg[`WC_EN_LSB +: 3];
  wire cyclic_en = wake_cfg_reg[`WC_CYCLIC];
  wire wr_mode = wr_stb && (addr == `OFF_MODE_CTRL);
  wire [1:0] wr_mode_val = wdata[`MC_MODE_LSB +: 2];
  // mode value 3 is refused, so it must not recapture the reference levels either
  wire enter_standby = wr_mode && !standby && (wr_mode_val != `MODE_ACTIVE) && (wr_mode_val != 2'h3);

  // timers
  wire t1_on;
  wire t1_start;
  wire t1_exp;
  wire t2_on;
  wire t2_start;
  wire t2_exp;
  wire [21:0] t1_per = t1_period(timer_cfg_reg[`TC_T1_PER_LSB +: 2]);
  wire [21:0] t1_ont = timer_cfg_reg[`TC_T1_ON] ? `T1_ON_20MS : `T1_ON_10MS;
  wire [21:0] t2_per = t2_period(timer_cfg_reg[`TC_T2_PER_LSB +: 2]);
  wire [21:0] t2_ont = timer_cfg_reg[`TC_T2_ON] ? `T2_ON_1MS : `T2_ON_100US;

  cyclic_timer timer1 (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick_reg),
    .restart(timer_restart_reg),
    .period_us(t1_per),
    .on_us(t1_ont),
    .on_phase(t1_on),
    .on_start(t1_start),
    .expired(t1_exp)
  );

  cyclic_timer timer2 (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick_reg),
    .restart(timer_restart_reg),
    .period_us(t2_per),
    .on_us(t2_ont),
    .on_phase(t2_on),
    .on_start(t2_start),
    .expired(t2_exp)
  );

  // static filter per contact input
  reg [9:0] sf_cnt_reg [0:2];
  reg [2:0] static_lvl_reg;
  reg [2:0] static_hit_reg;
  integer i;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < 3; i = i + 1) begin
        sf_cnt_reg[i] <= 10'h000;
      end
      static_lvl_reg <= 3'h0;
      static_hit_reg <= 3'h0;
    end else begin
      static_hit_reg <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        if (wu_lvl[i] == static_lvl_reg[i]) begin
          sf_cnt_reg[i] <= 10'h000;
        end else if (tick_reg) begin
          if (sf_cnt_reg[i] + 10'h001 >= `STATIC_FILT_US) begin
            static_lvl_reg[i] <= wu_lvl[i];
            static_hit_reg[i] <= 1'b1;
            sf_cnt_reg[i] <= 10'h000;
          end else begin
            sf_cnt_reg[i] <= sf_cnt_reg[i] + 10'h001;
          end
        end
      end
    end
  end

  // cyclic sense: delay after on-start, then a stable 16 us window
  reg [1:0] cs_state_reg;
  reg [9:0] cs_cnt_reg;
  reg [2:0] cs_snap_reg;
  reg [2:0] cyc_lvl_reg;
  reg [2:0] ref_lvl_reg;
  reg [2:0] cyc_hit_reg;
  wire cs_start = wake_cfg_reg[`WC_CYC_TSEL] ? t2_start : t1_start;
  wire [9:0] cs_delay = wake_cfg_reg[`WC_FILT_SEL] ? `CYC_DELAY_LONG_US : `CYC_DELAY_SHORT_US;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_state_reg <= CS_IDLE;
      cs_cnt_reg <= 10'h000;
      cs_snap_reg <= 3'h0;
      cyc_lvl_reg <= 3'h0;
      ref_lvl_reg <= 3'h0;
      cyc_hit_reg <= 3'h0;
    end else begin
      cyc_hit_reg <= 3'h0;
      if (enter_standby) begin
        ref_lvl_reg <= wu_lvl;
      end
      case (cs_state_reg)
        CS_IDLE: begin
          cs_cnt_reg <= 10'h000;
          if (cyclic_en && cs_start) begin
            cs_state_reg <= CS_DELAY;
          end
        end
        CS_DELAY: begin
          if (tick_reg) begin
            if (cs_cnt_reg + 10'h001 >= cs_delay) begin
              cs_state_reg <= CS_FILT;
              cs_cnt_reg <= 10'h000;
              cs_snap_reg <= wu_lvl;
            end else begin
              cs_cnt_reg <= cs_cnt_reg + 10'h001;
            end
          end
        end
        CS_FILT: begin
          if (wu_lvl != cs_snap_reg) begin
            cs_snap_reg <= wu_lvl;
            cs_cnt_reg <= 10'h000;
          end else if (tick_reg) begin
            if (cs_cnt_reg + 10'h001 >= `CYC_FILT_US) begin
              cs_state_reg <= CS_IDLE;
              cyc_lvl_reg <= cs_snap_reg;
              ref_lvl_reg <= cs_snap_reg;
              cyc_hit_reg <= cs_snap_reg ^ ref_lvl_reg;
            end else begin
              cs_cnt_reg <= cs_cnt_reg + 10'h001;
            end
          end
        end
        default: begin
          cs_state_reg <= CS_IDLE;
        end
      endcase
    end
  end

  // bus state stored on standby entry, filtered change wakes
  reg [1:0] bus_ref_reg;
  reg [9:0] bf_cnt_reg [0:1];
  reg [1:0] bus_hit_reg;
  integer j;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ref_reg <= 2'h3;
      bus_hit_reg <= 2'h0;
      for (j = 0; j < 2; j = j + 1) begin
        bf_cnt_reg[j] <= 10'h000;
      end
    end else begin
      bus_hit_reg <= 2'h0;
      if (enter_standby) begin
        bus_ref_reg <= bus_lvl;
      end
      for (j = 0; j < 2; j = j + 1) begin
        if (!standby || bus_lvl[j] == bus_ref_reg[j]) begin
          bf_cnt_reg[j] <= 10'h000;
        end else if (tick_reg) begin
          if (bf_cnt_reg[j] + 10'h001 >= `BUS_FILT_US) begin
            bus_hit_reg[j] <= 1'b1;
            bf_cnt_reg[j] <= 10'h000;
          end else begin
            bf_cnt_reg[j] <= bf_cnt_reg[j] + 10'h001;
          end
        end
      end
    end
  end

  // wake sources: contact, lin, can, timer
  wire [2:0] contact_hit = cyclic_en ? cyc_hit_reg : static_hit_reg;
  wire timer_exp = timer_cfg_reg[`TC_TWAKE_SEL] ? t2_exp : t1_exp;
  wire [3:0] wake_src;
  assign wake_src[0] = |(contact_hit & wu_en);
  assign wake_src[1] = bus_hit_reg[0] && wake_cfg_reg[`WC_LIN_EN];
  assign wake_src[2] = bus_hit_reg[1] && wake_cfg_reg[`WC_CAN_EN];
  assign wake_src[3] = timer_exp && timer_cfg_reg[`TC_TWAKE_EN];
  wire wake_now = standby && (|wake_src);

  // register writes and mode changes
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `MODE_ACTIVE;
      can_transceiver_activate_reg <= 1'b0;
      wake_cfg_reg <= `WAKE_CFG_RESET;
      timer_cfg_reg <= `TIMER_CFG_RESET;
      hs_cfg_reg <= 10'h000;
      src_reg <= 4'h0;
      timer_restart_reg <= 1'b0;
    end else begin
      timer_restart_reg <= wr_stb && (addr == `OFF_TIMER_CFG);
      if (wr_stb && addr == `OFF_WAKE_CFG) begin
        wake_cfg_reg <= wdata[10:0];
      end
      if (wr_stb && addr == `OFF_TIMER_CFG) begin
        timer_cfg_reg <= wdata[7:0];
      end
      if (wr_stb && addr == `OFF_HS_CFG) begin
        hs_cfg_reg <= wdata[9:0];
      end
      if (wr_mode) begin
        can_transceiver_activate_reg <= wdata[`MC_CAN_TRANSCEIVER_ACTIVATE];
      end
      // a wake beats a mode write in the same cycle
      if (wake_now) begin
        mode_reg <= `MODE_ACTIVE;
      end else if (wr_mode && wr_mode_val != 2'h3) begin
        mode_reg <= wr_mode_val;
      end
      // sticky sources: write one to clear, a new event wins
      if (wr_stb && addr == `OFF_STATUS) begin
        src_reg <= (src_reg & ~wdata[`ST_SRC_LSB +: 4]) | (wake_now ? wake_src : 4'h0);
      end else if (wake_now) begin
        src_reg <= src_reg | wake_src;
      end
    end
  end

  // wake pulses toward the microcontroller
  reg [9:0] int_cnt_reg;
  reg [9:0] rst_cnt_reg;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_cnt_reg <= 10'h000;
      rst_cnt_reg <= 10'h000;
      lin_receive_interrupt_pin_n <= 1'b1;
      micro_reset_out_n <= 1'b0;
      main_regulator_en <= 1'b1;
      watchdog_long_window <= 1'b0;
    end else begin
      watchdog_long_window <= wake_now;
      if (wake_now && mode_reg == `MODE_LP_STANDBY) begin
        int_cnt_reg <= `INT_PULSE_US;
        lin_receive_interrupt_pin_n <= 1'b0;
      end else if (int_cnt_reg == 10'h000) begin
        lin_receive_interrupt_pin_n <= 1'b1;
      end else if (tick_reg) begin
        int_cnt_reg <= int_cnt_reg - 10'h001;
      end
      if (wake_now && mode_reg == `MODE_BAT_STANDBY) begin
        rst_cnt_reg <= `RST_PULSE_US;
        micro_reset_out_n <= 1'b0;
      end else if (rst_cnt_reg == 10'h000) begin
        micro_reset_out_n <= 1'b1;
      end else if (tick_reg) begin
        rst_cnt_reg <= rst_cnt_reg - 10'h001;
      end
      main_regulator_en <= (mode_reg != `MODE_BAT_STANDBY) || wake_now;
    end
  end

  // pins driven from mode, configuration and the fail-safe pin
  integer k;
  reg [4:0] hs_next;
  always @* begin
    hs_next = 5'h00;
    for (k = 0; k < 5; k = k + 1) begin
      case (hs_cfg_reg[2 * k +: 2])
        `HS_ON: hs_next[k] = 1'b1;
        `HS_T1: hs_next[k] = t1_on;
        `HS_T2: hs_next[k] = t2_on;
        default: hs_next[k] = 1'b0;
      endcase
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      high_side_outputs <= 5'h00;
      wake_pull_up_en <= 3'h0;
      can_trx_standby <= 1'b1;
      fail_safe_output <= 1'b0;
      oscillator_run <= 1'b1;
    end else begin
      high_side_outputs <= hs_next;
      // pull-down while active
      wake_pull_up_en <= standby ? wake_cfg_reg[`WC_PULLUP_LSB +: 3] : 3'h0;
      can_trx_standby <= !can_transceiver_activate_reg || standby;
      fail_safe_output <= fs_lvl;
      oscillator_run <= !standby || cyclic_en;
    end
  end

  // register reads; cyclic mode shows only the last sampled levels
  wire [2:0] level_view = cyclic_en ? cyc_lvl_reg : static_lvl_reg;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h00000000;
    end else if (rd_stb) begin
      case (addr)
        `OFF_MODE_CTRL: rdata <= {29'h0, can_transceiver_activate_reg, mode_reg};
        `OFF_WAKE_CFG: rdata <= {21'h0, wake_cfg_reg};
        `OFF_TIMER_CFG: rdata <= {24'h0, timer_cfg_reg};
        `OFF_HS_CFG: rdata <= {22'h0, hs_cfg_reg};
        `OFF_STATUS: rdata <= {22'h0, fs_lvl, src_reg, mode_reg, level_view};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule // standby_wake_and_cyclic_sense

// ### dv/standby_wake_props.sv
`timescale 1ns/10ps
`include "standby_wake_defines.vh"
module standby_wake_props #(
  parameter US_CYCLES = 100
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [31:0] rdata,
  // pins from outside
  input wire [2:0] contact_wake_inputs,
  input wire lin_bus_rx,
  input wire can_bus_rx,
  input wire fail_safe_condition,
  // pins to outside
  input wire [4:0] high_side_outputs,
  input wire [2:0] wake_pull_up_en,
  input wire lin_receive_interrupt_pin_n,
  input wire micro_reset_out_n,
  input wire main_regulator_en,
  input wire watchdog_long_window,
  input wire can_trx_standby,
  input wire fail_safe_output,
  input wire oscillator_run
);
  logic [1:0] mode_sh;
  logic cyc_sh;
  logic [2:0] pu_sh;
  logic [9:0] hs_sh;
  logic [1:0] quiet;
  int low_cnt;
  wire [4:0] on_mask;
  wire [4:0] off_mask;
  // shadows lag a write by a few edges, so checks wait until the bus has been quiet
  wire settled = quiet == 2'h3;
  wire can_transceiver_activate_wr = wr_stb && addr == `OFF_MODE_CTRL && wdata[`MC_CAN_TRANSCEIVER_ACTIVATE];
  genvar k;
  for (k = 0; k < 5; k++) begin : g_hs
    assign on_mask[k] = hs_sh[2*k+1:2*k] == `HS_ON;
    assign off_mask[k] = hs_sh[2*k+1:2*k] == `HS_OFF;
  end
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode_sh <= `MODE_ACTIVE;
      cyc_sh <= 1'b0;
      pu_sh <= 3'h0;
      hs_sh <= 10'h000;
      quiet <= 2'h0;
      low_cnt <= 0;
    end else begin
      quiet <= (wr_stb || watchdog_long_window) ? 2'h0 : (settled ? quiet : quiet + 2'h1);
      low_cnt <= lin_receive_interrupt_pin_n ? 0 : low_cnt + 1;
      if (watchdog_long_window)
        mode_sh <= `MODE_ACTIVE;
      else if (wr_stb && addr == `OFF_MODE_CTRL && wdata[1:0] != 2'h3)
        mode_sh <= wdata[1:0];
      if (wr_stb && addr == `OFF_WAKE_CFG) begin
        cyc_sh <= wdata[`WC_CYCLIC];
        pu_sh <= wdata[5:3];
      end
      if (wr_stb && addr == `OFF_HS_CFG)
        hs_sh <= wdata[9:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_int_fall;
    $fell(lin_receive_interrupt_pin_n);
  endsequence
  sequence s_wake_seen;
    ##[0:3] (watchdog_long_window || $past(watchdog_long_window, 2));
  endsequence
  AST_RDATA_IDLE: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("read data not zero outside its slot");
  AST_INT_LEN: assert property ($rose(lin_receive_interrupt_pin_n) |-> low_cnt >= 55 * US_CYCLES && low_cnt <= 58 * US_CYCLES)
    else $error("interrupt pulse length off");
  AST_INT_FROM_WAKE: assert property (s_int_fall |-> s_wake_seen)
    else $error("interrupt pulse without a wake");
  AST_WAKE_SIGNAL: assert property ($rose(watchdog_long_window) |-> ##[0:2] (!lin_receive_interrupt_pin_n || !micro_reset_out_n))
    else $error("wake without interrupt or reset");
  AST_BAT_REG: assert property ($fell(micro_reset_out_n) |-> ##[0:2] main_regulator_en)
    else $error("regulator off at micro reset");
  AST_FSO_ON: assert property ($rose(fail_safe_condition) |-> ##[1:4] fail_safe_output)
    else $error("fail-safe output late");
  AST_FSO_OFF: assert property ((!fail_safe_condition) [*4] |-> !fail_safe_output)
    else $error("fail-safe output on without cause");
  // a wake back to active releases an already activated transceiver as well
  AST_CAN_TRANSCEIVER_ACTIVATE: assert property ($fell(can_trx_standby) |-> $past(can_transceiver_activate_wr, 2) || $past(watchdog_long_window))
    else $error("transceiver left standby without activation");
  AST_OSC: assert property (settled |-> oscillator_run == (mode_sh == `MODE_ACTIVE || cyc_sh))
    else $error("oscillator request wrong");
  AST_PULL: assert property (settled |-> wake_pull_up_en == (mode_sh == `MODE_ACTIVE ? 3'h0 : pu_sh))
    else $error("wake pull selection wrong");
  AST_HS_FIXED: assert property (settled |-> (high_side_outputs & (on_mask | off_mask)) == on_mask)
    else $error("fixed high-side output wrong");
  AST_QUIET_ACTIVE: assert property (settled && mode_sh == `MODE_ACTIVE |-> !watchdog_long_window)
    else $error("wake reported in active mode");
endmodule // standby_wake_props
bind standby_wake_and_cyclic_sense standby_wake_props #(.US_CYCLES(US_CYCLES)) standby_wake_props_i (
  .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .contact_wake_inputs(contact_wake_inputs), .lin_bus_rx(lin_bus_rx), .can_bus_rx(can_bus_rx),
  .fail_safe_condition(fail_safe_condition), .high_side_outputs(high_side_outputs), .wake_pull_up_en(wake_pull_up_en),
  .lin_receive_interrupt_pin_n(lin_receive_interrupt_pin_n), .micro_reset_out_n(micro_reset_out_n),
  .main_regulator_en(main_regulator_en), .watchdog_long_window(watchdog_long_window),
  .can_trx_standby(can_trx_standby), .fail_safe_output(fail_safe_output), .oscillator_run(oscillator_run));

// ### dv/contact_switches.sv
`timescale 1ns/10ps
module contact_switches (
  // supply and pull setting from the block
  input wire logic supply,
  input wire logic [2:0] pull_up_en,
  // contact state from the bench
  input wire logic [2:0] closed,
  input wire logic [2:0] supplied,
  // pin levels
  output logic [2:0] levels
);
  // an open or unpowered contact leaves the pin at the block's own pull level
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      levels[k] = (closed[k] && (!supplied[k] || supply)) ? ~pull_up_en[k] : pull_up_en[k];
    end
  end
endmodule // contact_switches

// ### dv/test_standby_wake_and_cyclic_sense.sv
`timescale 1ns/10ps
`include "standby_wake_defines.vh"
module test_standby_wake_and_cyclic_sense;
  // small microsecond scale keeps timer 2 periods short enough to simulate
  localparam int US = 2;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [2:0] closed = 3'h0;
  logic lin_bus_rx = 1'b1;
  logic can_bus_rx = 1'b1;
  logic fail_safe_condition = 1'b0;
  logic [31:0] rdata;
  logic [2:0] contact_wake_inputs;
  logic [4:0] high_side_outputs;
  logic [2:0] wake_pull_up_en;
  logic int_n, rst_n, reg_en, wd_long, can_stby, fso, osc;
  int err_total = 0;
  int checked = 0;
  int n;
  always #5 ref_clk = ~ref_clk;
  standby_wake_and_cyclic_sense #(.US_CYCLES(US)) standby_wake_and_cyclic_sense_i (.ref_clk(ref_clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .contact_wake_inputs(contact_wake_inputs), .lin_bus_rx(lin_bus_rx), .can_bus_rx(can_bus_rx),
    .fail_safe_condition(fail_safe_condition), .high_side_outputs(high_side_outputs),
    .wake_pull_up_en(wake_pull_up_en), .lin_receive_interrupt_pin_n(int_n), .micro_reset_out_n(rst_n),
    .main_regulator_en(reg_en), .watchdog_long_window(wd_long), .can_trx_standby(can_stby),
    .fail_safe_output(fso), .oscillator_run(osc));
  // contact 1 is powered from high-side output 0, the others are static
  contact_switches contact_switches_i (.supply(high_side_outputs[0]), .pull_up_en(wake_pull_up_en),
    .closed(closed), .supplied(3'h2), .levels(contact_wake_inputs));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string nm);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1;
    chk(nm, exp, rdata & m);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic drive(input logic [2:0] c, input logic l, input logic f);
    @(posedge ref_clk);
    closed <= c;
    lin_bus_rx <= l;
    fail_safe_condition <= f;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return int_n;
      1: return rst_n;
      default: return high_side_outputs[0];
    endcase
  endfunction
  task automatic waitfor(input int s, input logic v, input int lim);
    n = 0;
    #1;
    while (sig(s) !== v && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (sig(s) !== v) begin
      $display("MISMATCH wait_%0d expected %b seen timeout", s, v);
      err_total++;
      give_verdict();
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    cyc(4);
    chk("can_trx_standby", 1, can_stby);
    rd(`OFF_WAKE_CFG, 32'h7FF, 32'h607, "wake_cfg");
    rd(`OFF_TIMER_CFG, 32'hFF, 32'h0, "timer_cfg");
    rd(8'h14, 32'hFFFFFFFF, 32'h0, "unmapped");
    wr(`OFF_MODE_CTRL, 32'h4);
    cyc(3);
    chk("can_trx_active", 0, can_stby);
    wr(`OFF_MODE_CTRL, 32'h7);
    rd(`OFF_MODE_CTRL, 32'h7, 32'h4, "mode_refused");
    $display("test reset_values done");
    drive(3'h1, 1'b1, 1'b0);
    cyc(40 * US);
    drive(3'h0, 1'b1, 1'b0);
    cyc(2 * US);
    drive(3'h1, 1'b1, 1'b0);
    cyc(40 * US);
    rd(`OFF_STATUS, 32'h7, 32'h0, "level_early");
    cyc(30 * US);
    rd(`OFF_STATUS, 32'h7, 32'h1, "level_late");
    $display("test static_filter done");
    wr(`OFF_MODE_CTRL, 32'h5);
    cyc(4);
    chk("osc_lp_standby", 0, osc);
    drive(3'h0, 1'b1, 1'b0);
    waitfor(0, 1'b0, 100 * US);
    waitfor(0, 1'b1, 60 * US);
    chk("int_len_ok", 1, n >= 55 * US && n <= 58 * US);
    rd(`OFF_STATUS, 32'h1F8, 32'h020, "status_contact_wake");
    wr(`OFF_STATUS, 32'h1E0);
    $display("test lp_contact_wake done");
    wr(`OFF_MODE_CTRL, 32'h6);
    cyc(4);
    chk("regulator_off", 0, reg_en);
    drive(3'h0, 1'b0, 1'b1);
    cyc(10 * US);
    drive(3'h0, 1'b1, 1'b1);
    cyc(50 * US);
    chk("no_glitch_wake", 1, rst_n);
    chk("fail_safe_standby", 1, fso);
    drive(3'h0, 1'b0, 1'b1);
    waitfor(1, 1'b0, 60 * US);
    chk("regulator_on", 1, reg_en);
    waitfor(1, 1'b1, 150 * US);
    rd(`OFF_STATUS, 32'h3F8, 32'h240, "status_lin_wake");
    drive(3'h0, 1'b1, 1'b0);
    wr(`OFF_STATUS, 32'h1E0);
    $display("test bat_bus_wake done");
    wr(`OFF_MODE_CTRL, 32'h5);
    cyc(4);
    @(posedge ref_clk);
    can_bus_rx <= 1'b0;
    waitfor(0, 1'b0, 40 * US);
    waitfor(0, 1'b1, 60 * US);
    rd(`OFF_STATUS, 32'h1F8, 32'h080, "status_can_wake");
    wr(`OFF_STATUS, 32'h1E0);
    can_bus_rx <= 1'b1;
    $display("test lp_can_wake done");
    wr(`OFF_HS_CFG, 32'h7);
    wr(`OFF_WAKE_CFG, 32'h6C2);
    wr(`OFF_TIMER_CFG, 32'h0);
    wr(`OFF_MODE_CTRL, 32'h5);
    cyc(4);
    chk("osc_cyclic", 1, osc);
    chk("hs_fixed_on", 1, high_side_outputs[1]);
    waitfor(2, 1'b1, 11000 * US);
    chk("first_on_late", 1, n > 9800 * US);
    waitfor(2, 1'b0, 120 * US);
    chk("on_time_ok", 1, n >= 99 * US && n <= 102 * US);
    chk("no_wake_same_level", 1, int_n);
    drive(3'h2, 1'b1, 1'b0);
    waitfor(0, 1'b0, 10200 * US);
    chk("sampled_in_on_time", 1, high_side_outputs[0]);
    waitfor(0, 1'b1, 60 * US);
    rd(`OFF_STATUS, 32'h7, 32'h2, "cyclic_level");
    wr(`OFF_STATUS, 32'h1E0);
    $display("test cyclic_sense done");
    wr(`OFF_WAKE_CFG, 32'h638);
    wr(`OFF_TIMER_CFG, 32'hC0);
    wr(`OFF_MODE_CTRL, 32'h5);
    cyc(4);
    chk("pull_up_standby", 7, wake_pull_up_en);
    waitfor(0, 1'b0, 10200 * US);
    chk("timer_wake_time", 1, n >= 9900 * US && n <= 10010 * US);
    waitfor(0, 1'b1, 60 * US);
    chk("pull_down_active", 0, wake_pull_up_en);
    rd(`OFF_STATUS, 32'h1F8, 32'h100, "status_timer_wake");
    $display("test timer_wake done");
    give_verdict();
  end
endmodule // test_standby_wake_and_cyclic_sense
